// [lds_pkg.sv]
// lds_pkg: constants shared by both ends of the level detect / sync control
// assumes: 16-bit word addresses, 32-bit data, one device clock
package lds_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] LDS_ADDR_CONFIG    = 16'hf805;
    localparam logic [15:0] LDS_ADDR_START     = 16'hf806;
    localparam logic [15:0] LDS_ADDR_TEST_IN   = 16'hf807;
    localparam logic [15:0] LDS_ADDR_TEST_STB  = 16'hf808;
    localparam logic [15:0] LDS_ADDR_SYNC_OUT  = 16'hf809;
    localparam logic [15:0] LDS_ADDR_SYNC_LOOP = 16'hf80a;
    localparam logic [15:0] LDS_ADDR_SIGNATURE = 16'hf80b;
    localparam logic [15:0] LDS_ADDR_ORDER     = 16'hf820;
    localparam logic [10:0] LDS_ORDER_PAGE     = 11'h7c1;  // addr[15:5] of the order table
    localparam int          LDS_ORDER_DEPTH    = 32;
    // ----------------------------------------------------------------
    // config field positions
    // ----------------------------------------------------------------
    localparam int LDS_CFG_RECTIFY   = 21;
    localparam int LDS_CFG_FREE_RUN  = 20;
    localparam int LDS_CFG_LEAK_HI   = 19;
    localparam int LDS_CFG_LEAK_LO   = 18;
    localparam int LDS_CFG_MODE_HI   = 17;
    localparam int LDS_CFG_MODE_LO   = 16;
    localparam int LDS_CFG_WIDTH     = 22;
    localparam int LDS_STATUS_DONE   = 1;
    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [21:0] LDS_CONFIG_RST  = 22'h000000;
    localparam logic [15:0] LDS_TEST_IN_RST = 16'h0000;
    localparam logic [15:0] LDS_SIG_RST     = 16'h0000;
    localparam logic [4:0]  LDS_ORDER_RST   = 5'h00;
    localparam logic [1:0]  LDS_MODE_LEAKY  = 2'h0;
    localparam logic [1:0]  LDS_MODE_PEAK   = 2'h1;
    localparam logic [1:0]  LDS_MODE_INTEG  = 2'h2;
    localparam int          LDS_SAMPLE_FRAC = 16;      // sample sits above 16 fraction bits
endpackage : lds_pkg

// [lds_bus_if.sv]
// lds_bus_if: processor write/read bus between host and device
// assumes: both ends on core_clk_i; the testbench instantiates and joins them
`timescale 1ns/100ps
interface lds_bus_if;
    logic        wr_stb;    // one-cycle write strobe
    logic        rd_stb;    // one-cycle read strobe
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        rd_ack;    // one cycle after rd_stb

    modport host   (output wr_stb, output rd_stb, output addr, output wdata,
                    input rdata, input rd_ack);
    modport device (input wr_stb, input rd_stb, input addr, input wdata,
                    output rdata, output rd_ack);
endinterface : lds_bus_if

// [lds_host.sv]
// lds_host: processor end; turns user commands into bus strobes
// assumes: device answers every read exactly one cycle after rd_stb
`timescale 1ns/100ps
module lds_host
    import lds_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [15:0] cmd_addr_i,
    input  wire logic [31:0] cmd_data_i,
    output logic             cmd_ready_o,
    output logic             rsp_valid_o,
    output logic [31:0]      rsp_data_o,
    lds_bus_if.host          bus
);
    // ----------------------------------------------------------------
    // command issue
    // ----------------------------------------------------------------
    logic        wr_r, wr_nxt, rd_r, rd_nxt, busy_r, busy_nxt, rv_r, rv_nxt;
    logic        rdy_r, rdy_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt, rsp_r, rsp_nxt;

    // one strobe per command; a read waits for its answer
    always_comb begin
        wr_nxt   = 1'b0;
        rd_nxt   = 1'b0;
        rv_nxt   = 1'b0;
        busy_nxt = busy_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        rsp_nxt  = rsp_r;
        if (busy_r && bus.rd_ack) begin
            busy_nxt = 1'b0;
            rv_nxt   = 1'b1;
            rsp_nxt  = bus.rdata;
        end else if (!busy_r && !rd_r && cmd_valid_i) begin
            addr_nxt = cmd_addr_i;
            data_nxt = cmd_data_i;
            wr_nxt   = cmd_write_i;
            rd_nxt   = !cmd_write_i;
            busy_nxt = !cmd_write_i;
        end
        rdy_nxt  = !busy_nxt;                      // ready comes from its own flop
    end

    // registers of the issue path
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_r   <= 1'b0;
            rd_r   <= 1'b0;
            busy_r <= 1'b0;
            rv_r   <= 1'b0;
            rdy_r  <= 1'b1;
            addr_r <= 16'h0000;
            data_r <= 32'h00000000;
            rsp_r  <= 32'h00000000;
        end else begin
            wr_r   <= wr_nxt;
            rd_r   <= rd_nxt;
            busy_r <= busy_nxt;
            rv_r   <= rv_nxt;
            rdy_r  <= rdy_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            rsp_r  <= rsp_nxt;
        end
    end

    assign bus.wr_stb  = wr_r;
    assign bus.rd_stb  = rd_r;
    assign bus.addr    = addr_r;
    assign bus.wdata   = data_r;
    assign cmd_ready_o = rdy_r;
    assign rsp_valid_o = rv_r;
    assign rsp_data_o  = rsp_r;
endmodule // lds_host

// [lds_device.sv]
// lds_device: level detector, test input, sync strobes, signature, read order
// assumes: channel register bits and datapath words arrive on core_clk_i;
// sample and sync pins are asynchronous and are synchronised here
//
// Operation
// - rectify bit ones-complements negative samples
// - free run ignores interval; else stop
// - software may drop free run to freeze
// - leak field selects gain A
// - leaky mode: A*x plus (1-A)*y
// - software never selects peak mode
// - mode 10 is plain integrator
// - interval loads count minus two
// - start write clears accumulator, restarts interval
// - interval end sets done status bit 1
// - host test word feeds channels or detector
// - test enable: bit 11 or strobe, bit 12
// - test strobe write gives one enable pulse
// - sync-out write gives one-clock pin pulse
// - board adds at most two sync stages
// - loopback write also drives own sync input
// - signature: expected low, computed high half
// - order entry: channel bits, data type bits
// - types 0-3 select I and Q words
// - types 4-7 select magnitude, phase, gain
// - gated updates on enable; interpolated zeroes input while enabled
// - result readable as 32 bits
`timescale 1ns/100ps
module lds_device
    import lds_pkg::*;
(
    input  wire logic          core_clk_i,
    input  wire logic          nrst_i,
    lds_bus_if.device          bus,
    input  wire logic [15:0]   pin_sample_i,
    input  wire logic          pin_sample_enable_i,
    input  wire logic          test_enable_bit_i,
    input  wire logic          test_strobe_sel_i,
    input  wire logic          detector_use_test_i,
    input  wire logic          interp_mode_i,
    input  wire logic          sync_in_pin_i,
    input  wire logic [15:0]   bist_sig_i,
    input  wire logic          bist_done_i,
    input  wire logic [4:0]    order_slot_i,
    input  wire logic [3:0][23:0] i_data_i,
    input  wire logic [3:0][23:0] q_data_i,
    input  wire logic [3:0][23:0] mag_data_i,
    input  wire logic [3:0][15:0] phase_data_i,
    input  wire logic [3:0][15:0] gain_data_i,
    output logic [15:0]        test_sample_o,
    output logic               channel_sample_enable_o,
    output logic               sync_out_pin_o,
    output logic               sync_event_o,
    output logic               level_done_o,
    output logic [31:0]        level_result_o,
    output logic [15:0]        order_word_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [16:0] pin_s1_r, pin_s2_r;
    logic        sync_s1_r, sync_s2_r;

    // two stages before any logic looks at a pin
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1_r  <= 17'h00000;
            pin_s2_r  <= 17'h00000;
            sync_s1_r <= 1'b0;
            sync_s2_r <= 1'b0;
        end else begin
            pin_s1_r  <= {pin_sample_enable_i, pin_sample_i};
            pin_s2_r  <= pin_s1_r;
            sync_s1_r <= sync_in_pin_i;
            sync_s2_r <= sync_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // register file and strobes
    // ----------------------------------------------------------------
    logic [21:0] cfg_r, cfg_nxt;
    logic [15:0] test_in_r, test_in_nxt, sig_exp_r, sig_exp_nxt, sig_got_r, sig_got_nxt;
    logic [4:0]  order_r [LDS_ORDER_DEPTH];
    logic        start_w, test_stb_w, sync_out_w, sync_loop_w, order_w;
    logic        ten_r, ten_nxt, so_r, so_nxt, sev_r, sev_nxt;

    assign start_w     = bus.wr_stb && bus.addr == LDS_ADDR_START;      // data ignored
    assign test_stb_w  = bus.wr_stb && bus.addr == LDS_ADDR_TEST_STB;
    assign sync_out_w  = bus.wr_stb && bus.addr == LDS_ADDR_SYNC_OUT;
    assign sync_loop_w = bus.wr_stb && bus.addr == LDS_ADDR_SYNC_LOOP;
    assign order_w     = bus.wr_stb && bus.addr[15:5] == LDS_ORDER_PAGE;

    // stored registers and strobe outputs
    always_comb begin
        cfg_nxt     = cfg_r;
        test_in_nxt = test_in_r;
        sig_exp_nxt = sig_exp_r;
        sig_got_nxt = bist_done_i ? bist_sig_i : sig_got_r;
        if (bus.wr_stb && bus.addr == LDS_ADDR_CONFIG)
            cfg_nxt = bus.wdata[LDS_CFG_WIDTH-1:0];                     // bits 31:22 dropped
        if (bus.wr_stb && bus.addr == LDS_ADDR_TEST_IN)
            test_in_nxt = bus.wdata[15:0];
        if (bus.wr_stb && bus.addr == LDS_ADDR_SIGNATURE)
            sig_exp_nxt = bus.wdata[15:0];
        ten_nxt = test_strobe_sel_i ? test_stb_w : test_enable_bit_i;
        so_nxt  = sync_out_w | sync_loop_w;
        sev_nxt = sync_s2_r | sync_loop_w;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_r     <= LDS_CONFIG_RST;
            test_in_r <= LDS_TEST_IN_RST;
            sig_exp_r <= LDS_SIG_RST;
            sig_got_r <= LDS_SIG_RST;
            ten_r     <= 1'b0;
            so_r      <= 1'b0;
            sev_r     <= 1'b0;
        end else begin
            cfg_r     <= cfg_nxt;
            test_in_r <= test_in_nxt;
            sig_exp_r <= sig_exp_nxt;
            sig_got_r <= sig_got_nxt;
            ten_r     <= ten_nxt;
            so_r      <= so_nxt;
            sev_r     <= sev_nxt;
        end
    end

    // read-order table, one entry per generate step
    genvar gi;
    generate
        for (gi = 0; gi < LDS_ORDER_DEPTH; gi++) begin : g_order
            logic [4:0] ent_nxt;
            always_comb begin
                ent_nxt = order_r[gi];
                if (order_w && bus.addr[4:0] == 5'(gi))
                    ent_nxt = bus.wdata[4:0];
            end
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i)
                    order_r[gi] <= LDS_ORDER_RST;
                else
                    order_r[gi] <= ent_nxt;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // level detector
    // ----------------------------------------------------------------
    logic [31:0] acc_r, acc_nxt;
    logic [16:0] cnt_r, cnt_nxt;
    logic        done_r, done_nxt;
    logic [15:0] raw, rect;
    logic        en, step;
    logic [31:0] x_int, x_frac, leak_d;
    logic [1:0]  mode;

    // sample source, rectification, update condition
    always_comb begin
        raw  = detector_use_test_i ? test_in_r : pin_s2_r[15:0];
        en   = detector_use_test_i ? ten_r : pin_s2_r[16];
        rect = (cfg_r[LDS_CFG_RECTIFY] && raw[15]) ? ~raw : raw;
        if (interp_mode_i && en)
            rect = 16'h0000;
        step = interp_mode_i ? 1'b1 : en;
        mode = cfg_r[LDS_CFG_MODE_HI:LDS_CFG_MODE_LO];
        x_int  = {{16{rect[15]}}, rect};
        x_frac = {rect, 16'h0000};
        leak_d = x_frac - acc_r;
        case (cfg_r[LDS_CFG_LEAK_HI:LDS_CFG_LEAK_LO])
            2'h0:    leak_d = leak_d;
            2'h1:    leak_d = {{8{leak_d[31]}}, leak_d[31:8]};
            2'h2:    leak_d = {{12{leak_d[31]}}, leak_d[31:12]};
            default: leak_d = {{LDS_SAMPLE_FRAC{leak_d[31]}}, leak_d[31:16]};
        endcase
    end

    // accumulate while running; stop mode freezes at interval end
    always_comb begin
        acc_nxt  = acc_r;
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (start_w) begin
            acc_nxt  = 32'h00000000;
            cnt_nxt  = 17'h00000;
            done_nxt = 1'b0;
        end else if (step && (cfg_r[LDS_CFG_FREE_RUN] || !done_r)) begin
            case (mode)
                LDS_MODE_LEAKY: acc_nxt = acc_r + leak_d;
                LDS_MODE_INTEG: acc_nxt = acc_r + x_int;
                LDS_MODE_PEAK:  acc_nxt = acc_r;                         // unsupported
                default:        acc_nxt = acc_r;
            endcase
            if (!cfg_r[LDS_CFG_FREE_RUN]) begin
                cnt_nxt = cnt_r + 17'h00001;
                if (cnt_r == {1'b0, cfg_r[15:0]} + 17'h00001)            // load+2 samples
                    done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            acc_r  <= 32'h00000000;
            cnt_r  <= 17'h00000;
            done_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read data and read-order word
    // ----------------------------------------------------------------
    logic [31:0] rd_r, rd_nxt;
    logic        ack_r;
    logic [15:0] ow_r, ow_nxt;
    logic [4:0]  code;

    // registered read answer, zero for unmapped addresses
    always_comb begin
        case (bus.addr)
            LDS_ADDR_CONFIG:    rd_nxt = {10'h000, cfg_r};
            LDS_ADDR_START:     rd_nxt = acc_r;
            LDS_ADDR_TEST_IN:   rd_nxt = {16'h0000, test_in_r};
            LDS_ADDR_SIGNATURE: rd_nxt = {sig_got_r, sig_exp_r};
            default:            rd_nxt = 32'h00000000;
        endcase
        if (bus.addr[15:5] == LDS_ORDER_PAGE)
            rd_nxt = {27'h0000000, order_r[bus.addr[4:0]]};
        if (!bus.rd_stb)
            rd_nxt = rd_r;
    end

    // data word picked by the selected order entry
    always_comb begin
        code = order_r[order_slot_i];
        case (code[2:0])
            3'h0:    ow_nxt = i_data_i[code[4:3]][23:8];
            3'h1:    ow_nxt = {i_data_i[code[4:3]][7:0], 8'h00};
            3'h2:    ow_nxt = q_data_i[code[4:3]][23:8];
            3'h3:    ow_nxt = {q_data_i[code[4:3]][7:0], 8'h00};
            3'h4:    ow_nxt = mag_data_i[code[4:3]][23:8];
            3'h5:    ow_nxt = {mag_data_i[code[4:3]][7:0], 8'h00};
            3'h6:    ow_nxt = phase_data_i[code[4:3]];
            default: ow_nxt = gain_data_i[code[4:3]];
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_r  <= 32'h00000000;
            ack_r <= 1'b0;
            ow_r  <= 16'h0000;
        end else begin
            rd_r  <= rd_nxt;
            ack_r <= bus.rd_stb;
            ow_r  <= ow_nxt;
        end
    end

    // all outputs come from flops
    assign bus.rdata               = rd_r;
    assign bus.rd_ack              = ack_r;
    assign test_sample_o           = test_in_r;
    assign channel_sample_enable_o = ten_r;
    assign sync_out_pin_o          = so_r;
    assign sync_event_o            = sev_r;
    assign level_done_o            = done_r;
    assign level_result_o          = acc_r;
    assign order_word_o            = ow_r;
endmodule // lds_device

// [lds_props.sv]
// lds_props: bus checks on the link between host and device ends
// assumes: plain signals of lds_bus_if, clock core_clk_i, reset nrst_i
`timescale 1ns/100ps
module lds_props
    import lds_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [15:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        rd_ack
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // ----------------------------------------------------------------
    // read handshake
    // ----------------------------------------------------------------
    // every read answered one cycle later, never twice
    AST_ACK_AFTER_RD: assert property (rd_stb |=> rd_ack ##1 !rd_ack)
        else $error("read answer missing or too long");
    AST_ACK_CAUSE: assert property (rd_ack |-> $past(rd_stb))
        else $error("read answer without read");
    // host leaves a gap after each read
    AST_RD_SPACING: assert property (rd_stb |=> !rd_stb [*2])
        else $error("reads too close");
    AST_NO_OVERLAP: assert property (!(wr_stb && rd_stb))
        else $error("read and write together");
    AST_RDATA_HOLD: assert property (!rd_ack |-> rdata == $past(rdata))
        else $error("read data moved without answer");
    // ----------------------------------------------------------------
    // read data shape
    // ----------------------------------------------------------------
    AST_CFG_UPPER: assert property (rd_stb && addr == LDS_ADDR_CONFIG
        |=> rdata[31:22] == 10'h0)
        else $error("config upper bits not zero");
    AST_ORDER_WIDTH: assert property (rd_stb && addr[15:5] == LDS_ORDER_PAGE
        |=> rdata[31:5] == 27'h0)
        else $error("order entry wider than five bits");
    AST_TEST_WIDTH: assert property (rd_stb && addr == LDS_ADDR_TEST_IN
        |=> rdata[31:16] == 16'h0)
        else $error("test word wider than sixteen bits");
    // main scenarios reached
    cover property (rd_ack);
    cover property (wr_stb && addr == LDS_ADDR_START);
    cover property (wr_stb && addr == LDS_ADDR_SYNC_LOOP);
endmodule // lds_props

// [test_level_detect_sync_ctrl.sv]
// test_level_detect_sync_ctrl: host and device joined, driven from host user side
// assumes: lds_pkg, lds_bus_if, lds_host, lds_device, lds_props compiled before
`timescale 1ns/100ps
module test_level_detect_sync_ctrl
    import lds_pkg::*;
;
    logic             core_clk_i, nrst_i, cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic [15:0]      cmd_addr, test_sample, order_word, bsig;
    logic [31:0]      cmd_data, rsp_data, result, rs, got;
    logic             ten_bit, tsel, det_test, interp, bdone, ch_en, sync_out, sync_ev, done;
    logic [4:0]       slot;
    logic [1:0]       brd;
    logic [3:0][23:0] idat, qdat, mdat;
    logic [3:0][15:0] pdat, gdat;
    int               fails, tests_run, n_out, n_ev, n_en;
    lds_bus_if bus();
    lds_host lds_host_i(.core_clk_i, .nrst_i, .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .bus(bus));
    lds_device lds_device_i(.core_clk_i, .nrst_i, .bus(bus), .pin_sample_i(16'h0),
        .pin_sample_enable_i(1'b0), .test_enable_bit_i(ten_bit), .test_strobe_sel_i(tsel),
        .detector_use_test_i(det_test), .interp_mode_i(interp), .sync_in_pin_i(brd[1]),
        .bist_sig_i(bsig), .bist_done_i(bdone), .order_slot_i(slot), .i_data_i(idat),
        .q_data_i(qdat), .mag_data_i(mdat), .phase_data_i(pdat), .gain_data_i(gdat),
        .test_sample_o(test_sample), .channel_sample_enable_o(ch_en),
        .sync_out_pin_o(sync_out), .sync_event_o(sync_ev), .level_done_o(done),
        .level_result_o(result), .order_word_o(order_word));
    lds_props lds_props_i(.core_clk_i, .nrst_i, .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb),
        .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rd_ack(bus.rd_ack));
    // ----------------------------------------------------------------
    // clock, pulse counters, helpers
    // ----------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    // board path from sync out back to sync in, two register stages
    always @(posedge core_clk_i) brd <= {brd[0], sync_out};
    // one-cycle outputs are counted at the falling edge
    always @(negedge core_clk_i) begin
        n_out += int'(sync_out === 1'b1);
        n_ev += int'(sync_ev === 1'b1);
        n_en += int'(ch_en === 1'b1);
    end
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // order word expected for channel c and data type d
    function automatic logic [15:0] oexp(input logic [1:0] c, input logic [2:0] d);
        case (d)
            3'h0: return idat[c][23:8];
            3'h1: return {idat[c][7:0], 8'h00};
            3'h2: return qdat[c][23:8];
            3'h3: return {qdat[c][7:0], 8'h00};
            3'h4: return mdat[c][23:8];
            3'h5: return {mdat[c][7:0], 8'h00};
            3'h6: return pdat[c];
            default: return gdat[c];
        endcase
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input logic ok);
        if (!ok) begin
            fails++;
            complete_run();
        end
    endtask
    // one command held until taken; a read waits for its answer
    task automatic cmd(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge core_clk_i);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_data <= d;
        do @(negedge core_clk_i); while (cmd_ready !== 1'b1 && ++i < 50);
        @(posedge core_clk_i);
        cmd_valid <= 1'b0;
        if (!w) begin
            do @(negedge core_clk_i); while (rsp_valid !== 1'b1 && ++i < 50);
            got = rsp_data;
        end
        tmo(i < 50);
    endtask
    task automatic wait_done(input int lim);
        int i;
        i = 0;
        do @(negedge core_clk_i); while (done !== 1'b1 && ++i < lim);
        tmo(i < lim);
    endtask
    // program the detector, then start it with random ignored data
    task automatic run(input logic rect, fr, input logic [1:0] lk, md, input int n);
        cmd(1'b1, LDS_ADDR_CONFIG, {10'h0, rect, fr, lk, md, 16'(n - 2)});
        cmd(1'b1, LDS_ADDR_START, rnd());
        @(negedge core_clk_i);  // start clears done at the next edge
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int k, n, a, e;
        logic [31:0] v, b;
        logic [15:0] x, s;
        {fails, tests_run, n_out, n_ev, n_en} = '0;
        {nrst_i, cmd_valid, cmd_write, cmd_addr, cmd_data, bsig, slot} = '0;
        {ten_bit, tsel, interp, bdone} = '0;
        det_test = 1'b1;
        rs = 32'd8535;
        for (k = 0; k < 4; k++) begin
            v = rnd();
            idat[k] = v[23:0];
            v = rnd();
            qdat[k] = v[23:0];
            v = rnd();
            mdat[k] = v[23:0];
            v = rnd();
            {pdat[k], gdat[k]} = v;
        end
        repeat (12) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk({16'h0, order_word}, {16'h0, idat[0][23:8]});
        cmd(1'b0, LDS_ADDR_CONFIG, 32'h0);
        chk(got, {10'h0, LDS_CONFIG_RST});
        // config upper bits dropped, test word and signature halves
        v = rnd();
        cmd(1'b1, LDS_ADDR_CONFIG, v);
        cmd(1'b0, LDS_ADDR_CONFIG, 32'h0);
        chk(got, {10'h0, v[21:0]});
        cmd(1'b1, LDS_ADDR_TEST_IN, v);
        repeat (2) @(negedge core_clk_i);
        chk({16'h0, test_sample}, {16'h0, v[15:0]});
        cmd(1'b0, LDS_ADDR_TEST_IN, 32'h0);
        chk(got, {16'h0, v[15:0]});
        b = rnd();
        cmd(1'b1, LDS_ADDR_SIGNATURE, v);
        @(posedge core_clk_i);
        bsig <= b[15:0];
        bdone <= 1'b1;
        @(posedge core_clk_i);
        bdone <= 1'b0;
        cmd(1'b0, LDS_ADDR_SIGNATURE, 32'h0);
        chk(got, {b[15:0], v[15:0]});
        // strobes: sync out, loopback, test strobe selected and not
        for (k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            tsel <= (k == 2);
            {n_out, n_ev, n_en} = '0;
            cmd(1'b1, k == 0 ? LDS_ADDR_SYNC_OUT : k == 1 ? LDS_ADDR_SYNC_LOOP :
                LDS_ADDR_TEST_STB, rnd());
            repeat (10) @(negedge core_clk_i);
            chk(32'(n_out), 32'(k < 2));
            chk(32'(n_ev), 32'(k < 2 ? k + 1 : 0));
            chk(32'(n_en), 32'(k == 2));
        end
        @(posedge core_clk_i);
        tsel <= 1'b0;
        ten_bit <= 1'b1;
        repeat (3) @(negedge core_clk_i);
        chk({31'h0, ch_en}, 32'h1);
        // integrator, rectify on and off, shortest and longest interval
        for (k = 0; k < 3; k++) begin
            v = rnd();
            x = v[15:0] | 16'h8000;
            n = k == 0 ? 2 : k == 1 ? 5 : 65537;
            s = (k == 1) ? ~x : x;
            e = n * int'($signed(s));
            cmd(1'b1, LDS_ADDR_TEST_IN, {16'h0, x});
            run(k == 1, 1'b0, 2'h0, LDS_MODE_INTEG, n);
            wait_done(70000);
            chk(result, e);
            repeat (5) @(negedge core_clk_i);
            cmd(1'b0, LDS_ADDR_START, 32'h0);
            chk(got, e);
        end
        // free run keeps adding and never finishes
        run(1'b0, 1'b1, 2'h1, LDS_MODE_LEAKY, 2);
        repeat (4) @(negedge core_clk_i);
        a = result;
        repeat (3) @(negedge core_clk_i);
        repeat (3) a = a + (((int'($signed(x)) <<< 16) - a) >>> 8);
        chk(result, a);
        chk({31'h0, done}, 32'h0);
        // dropping free run ends the interval and freezes the result
        cmd(1'b1, LDS_ADDR_CONFIG, {10'h0, 4'h1, LDS_MODE_LEAKY, 16'h0});
        repeat (5) @(negedge core_clk_i);
        v = result;
        repeat (3) @(negedge core_clk_i);
        chk(result, v);
        // leaky integrator over every leak code, two updates each
        for (k = 0; k < 4; k++) begin
            v = rnd();
            x = v[15:0];
            a = 0;
            repeat (2) a = a + (((int'($signed(x)) <<< 16) - a) >>> (k == 0 ? 0 : 4 + 4 * k));
            cmd(1'b1, LDS_ADDR_TEST_IN, {16'h0, x});
            run(1'b0, 1'b0, 2'(k), LDS_MODE_LEAKY, 2);
            wait_done(50);
            chk(result, a);
        end
        // interpolated zeroes input while enabled; gated without enable stalls
        @(posedge core_clk_i);
        interp <= 1'b1;
        run(1'b0, 1'b0, 2'h0, LDS_MODE_INTEG, 4);
        wait_done(50);
        chk(result, 32'h0);
        @(posedge core_clk_i);
        interp <= 1'b0;
        ten_bit <= 1'b0;
        run(1'b0, 1'b0, 2'h0, LDS_MODE_INTEG, 2);
        repeat (20) @(negedge core_clk_i);
        chk({31'h0, done}, 32'h0);
        // read order table over every data type
        for (k = 0; k < 8; k++) begin
            v = rnd();
            cmd(1'b1, LDS_ADDR_ORDER + 16'(v[4:0]), {27'h0, v[9:8], 3'(k)});
            cmd(1'b0, LDS_ADDR_ORDER + 16'(v[4:0]), 32'h0);
            chk(got, {27'h0, v[9:8], 3'(k)});
            @(posedge core_clk_i);
            slot <= v[4:0];
            repeat (2) @(negedge core_clk_i);
            chk({16'h0, order_word}, {16'h0, oexp(v[9:8], 3'(k))});
        end
        cmd(1'b0, 16'h1234, 32'h0);
        chk(got, 32'h0);
        complete_run();
    end
endmodule // test_level_detect_sync_ctrl
